// *** hdl/acs_pkg.sv ***
package acs_pkg;
   // Register map
   localparam int         NREG        = 8;
   localparam int         REG_W       = 9;
   localparam logic [3:0] COLPAR_ADDR = 4'h6;
   localparam logic [3:0] STATUS_ADDR = 4'h7;
   localparam logic [8:0] CFG_RESET   = 9'h000;
   localparam logic [8:0] STATUS_RESET = 9'h001;
   localparam logic [8:0] SRST_KEEP   = 9'h003;
   localparam int         ROW_PAR_BIT = 0;
   // Status fields
   localparam int ST_CHX    = 6;
   localparam int ST_AGC    = 5;
   localparam int ST_CHAN_X_WOKE  = 2;
   localparam int ST_ALARM  = 1;
   localparam int ST_PERR   = 0;
   // Serial frame layout, most significant bit first
   localparam int         FRAME_BITS = 16;
   localparam logic [4:0] FRAME_LEN  = 5'h10;
   localparam logic [4:0] CNT_MAX    = 5'h1f;
   localparam int         CMD_LSB    = 13;
   localparam int         ADDR_LSB   = 9;
   localparam logic [6:0] READ_PAD   = 7'h00;
   // Command codes
   localparam logic [2:0] CMD_CLAMP_ON  = 3'h0;
   localparam logic [2:0] CMD_CLAMP_OFF = 3'h1;
   localparam logic [2:0] CMD_SLEEP     = 3'h2;
   localparam logic [2:0] CMD_PRES_ON   = 3'h3;
   localparam logic [2:0] CMD_PRES_OFF  = 3'h4;
   localparam logic [2:0] CMD_SOFT_RST  = 3'h5;
   localparam logic [2:0] CMD_READ      = 3'h6;
   localparam logic [2:0] CMD_WRITE     = 3'h7;

   typedef struct packed {
      logic [2:0]                  cs_s;
      logic [2:0]                  sck_s;
      logic [1:0]                  sdi_s;
      logic [1:0][2:0]             act_s;
      logic [1:0][2:0]             wake_s;
      logic [1:0]                  agc_s;
      logic [1:0]                  alarm_s;
      logic [1:0]                  mode_s;
      logic [FRAME_BITS-1:0]       shift;
      logic [4:0]                  nbits;
      logic [FRAME_BITS-1:0]       out_sh;
      logic                        sdo;
      logic [NREG-2:0][REG_W-1:0]  cfg;
      logic [REG_W-1:0]            status;
      logic                        sleep;
      logic                        clamp;
      logic                        agc_pres;
      logic                        srst;
   } acs_state_t;
endpackage

// *** hdl/acs_regs.sv ***
// Behaviour
// R1 - Eight registers in all, including column parity and status registers.
// R2 - All registers but status read/write over the serial port; status is read-only.
// R3 - Bit 0 of each non-status register makes its ones count odd.
// R4 - Status is nine bits: activity, gain control, wake causes, alarm, parity.
// R5 - Gain control active bit sets while gain control is active.
// R6 - Each channel wake bit sets when that channel wakes the front end.
// R7 - After power-on, status bits 8..1 read zero, parity error reads one.
// R8 - Reading the status register clears the alarm bit only.
// R9 - Sleep command leaves every status bit unchanged.
// R10 - Executed soft reset clears bits 8..2, keeps alarm and parity error.
// R11 - Soft reset outside active mode is ignored, except that it still wakes the front end from sleep.
// R12 - Any command but sleep wakes the front end from sleep.
// R13 - Parity error bit tracks live row and column odd-parity checks.
`timescale 1ns/1ps
`default_nettype none
module acs_regs
   import acs_pkg::*;
(
   input  wire logic                     clk_sys,
   input  wire logic                     reset_n,
   input  wire logic                     spi_cs_n,
   input  wire logic                     spi_sck,
   input  wire logic                     spi_sdi,
   output logic                          spi_sdo,
   input  wire logic [2:0]               chan_active,
   input  wire logic [2:0]               chan_woke,
   input  wire logic                     gain_ctrl_active,
   input  wire logic                     alarm_timeout,
   input  wire logic                     front_end_active,
   output logic                          sleep_mode,
   output logic                          clamp_on,
   output logic                          agc_preserve,
   output logic                          soft_reset_pulse,
   output logic [(NREG-1)*REG_W-1:0]     cfg_regs,
   output logic [REG_W-1:0]              front_end_status
);
   // Field positions below assume this exact bank shape
   if (NREG != 8 || REG_W != 9) begin : g_shape_chk
      $error("Register bank must be eight registers of nine bits"); // [R1]
   end

   ////////////////////////////////////////////////////////////////////////////
   // Parity checker, shared by logic and checks
   function automatic logic par_fail(input logic [NREG-2:0][REG_W-1:0] c);
      logic f;
      logic col;
      f = 1'b0;
      for (int r = 0; r < NREG-1; r++) begin
         if (!(^c[r])) begin
            f = 1'b1; // [R3]
         end
      end
      // Column zero holds the row parity bits, so it is not checked
      for (int b = 1; b < REG_W; b++) begin
         col = 1'b0;
         for (int r = 0; r < NREG-1; r++) begin
            col = col ^ c[r][b];
         end
         if (!col) begin
            f = 1'b1;
         end
      end
      return f;
   endfunction

   acs_state_t q;
   acs_state_t d;
   logic       perr;
   logic       frame_done;
   logic [2:0] cmd_w;
   logic [3:0] addr_w;
   logic [8:0] data_w;
   logic       evt_any;

   assign perr       = par_fail(q.cfg);
   // Commands only act on a complete frame; short or long frames drop
   assign frame_done = q.cs_s[1] & ~q.cs_s[2] & (q.nbits == FRAME_LEN);
   assign cmd_w      = q.shift[FRAME_BITS-1:CMD_LSB];
   assign addr_w     = q.shift[CMD_LSB-1:ADDR_LSB];
   assign data_w     = q.shift[ADDR_LSB-1:0];
   assign evt_any    = (|q.act_s[1]) | (|q.wake_s[1]) | q.agc_s[1] | q.alarm_s[1];

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic sck_rise;
      logic sck_fall;
      logic cs_fall;
      logic [8:0] rdata;
      sck_rise = q.sck_s[1] & ~q.sck_s[2];
      sck_fall = ~q.sck_s[1] & q.sck_s[2];
      cs_fall  = ~q.cs_s[1] & q.cs_s[2];
      rdata    = 9'h000;
      d        = q;
      d.srst   = 1'b0;
      // Pins cross in through two flops before anything looks at them
      d.cs_s    = {q.cs_s[1:0], spi_cs_n};
      d.sck_s   = {q.sck_s[1:0], spi_sck};
      d.sdi_s   = {q.sdi_s[0], spi_sdi};
      d.act_s   = {q.act_s[0], chan_active};
      d.wake_s  = {q.wake_s[0], chan_woke};
      d.agc_s   = {q.agc_s[0], gain_ctrl_active};
      d.alarm_s = {q.alarm_s[0], alarm_timeout};
      d.mode_s  = {q.mode_s[0], front_end_active};
      if (cs_fall) begin
         d.nbits = 5'h00;
         d.sdo   = q.out_sh[FRAME_BITS-1];
      end else if (!q.cs_s[1]) begin
         if (sck_rise) begin
            d.shift = {q.shift[FRAME_BITS-2:0], q.sdi_s[1]};
            if (q.nbits != CNT_MAX) begin
               d.nbits = q.nbits + 5'h01;
            end
         end
         if (sck_fall) begin
            d.out_sh = {q.out_sh[FRAME_BITS-2:0], 1'b0};
            d.sdo    = q.out_sh[FRAME_BITS-2];
         end
      end
      if (frame_done) begin
         if (q.sleep && cmd_w != CMD_SLEEP) begin
            d.sleep = 1'b0; // [R12]
         end
         unique case (cmd_w)
            CMD_CLAMP_ON:  d.clamp = 1'b1;
            CMD_CLAMP_OFF: d.clamp = 1'b0;
            CMD_SLEEP:     d.sleep = 1'b1; // [R9]
            CMD_PRES_ON:   d.agc_pres = 1'b1;
            CMD_PRES_OFF:  d.agc_pres = 1'b0;
            CMD_SOFT_RST: begin
               // Standby or sleep: no pulse and no status clear, though a sleeping front end still wakes
               if (q.mode_s[1]) begin // [R11]
                  d.srst     = 1'b1;
                  d.agc_pres = 1'b0;
                  d.status   = q.status & SRST_KEEP; // [R10]
               end
            end
            CMD_READ: begin
               if (addr_w == STATUS_ADDR) begin
                  rdata = q.status;
                  d.status[ST_ALARM] = 1'b0; // [R8]
               end else if (addr_w < STATUS_ADDR) begin
                  rdata = q.cfg[addr_w[2:0]]; // [R2]
               end
               // Read data leaves on the following frame
               d.out_sh = {READ_PAD, rdata};
            end
            CMD_WRITE: begin
               // Status address and holes swallow the write
               if (addr_w < STATUS_ADDR) begin
                  d.cfg[addr_w[2:0]] = data_w; // [R2]
               end
            end
         endcase
      end
      // Sets applied last so an event never loses to a clear
      for (int i = 0; i < 3; i++) begin
         if (q.act_s[1][i]) begin
            d.status[ST_CHX+i] = 1'b1; // [R4]
         end
         if (q.wake_s[1][i]) begin
            d.status[ST_CHAN_X_WOKE+i] = 1'b1; // [R6]
         end
      end
      if (q.agc_s[1]) begin
         d.status[ST_AGC] = 1'b1; // [R5]
      end
      if (q.alarm_s[1]) begin
         d.status[ST_ALARM] = 1'b1;
      end
      d.status[ST_PERR] = perr; // [R13]
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         q        <= '0;
         q.cs_s   <= 3'h7;
         q.cfg    <= {(NREG-1){CFG_RESET}};
         q.status <= STATUS_RESET; // [R7]
      end else begin
         q <= d;
      end
   end

   assign spi_sdo          = q.sdo;
   assign sleep_mode       = q.sleep;
   assign clamp_on         = q.clamp;
   assign agc_preserve     = q.agc_pres;
   assign soft_reset_pulse = q.srst;
   assign cfg_regs         = q.cfg;
   assign front_end_status = q.status;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_status_ro: assert property ( // [R2]
      frame_done && cmd_w == CMD_WRITE && addr_w == STATUS_ADDR |=> $stable(q.cfg))
      else $error("Status write changed the bank");
   a_write_store: assert property ( // [R2]
      frame_done && cmd_w == CMD_WRITE && addr_w < STATUS_ADDR
      |=> q.cfg[$past(addr_w[2:0])] == $past(data_w)) else $error("Write not stored");
   a_row_parity: assert property (q.cfg == '0 |=> q.status[ST_PERR]) // [R3]
      else $error("Even rows not flagged");
   // An executed soft reset may legally clear the bit in the second cycle
   a_wake_sticky: assert property ( // [R6]
      q.wake_s[1][0] |=> q.status[ST_CHAN_X_WOKE] ##1 (q.status[ST_CHAN_X_WOKE] || q.srst))
      else $error("Wake bit not held");
   a_alarm_read: assert property ( // [R8]
      frame_done && cmd_w == CMD_READ && addr_w == STATUS_ADDR && !q.alarm_s[1]
      |=> !q.status[ST_ALARM]) else $error("Alarm not cleared");
   a_sleep_keep: assert property ( // [R9]
      frame_done && cmd_w == CMD_SLEEP && !evt_any
      |=> $stable(q.status) && q.sleep) else $error("Sleep touched status");
   a_srst_clear: assert property ( // [R10]
      frame_done && cmd_w == CMD_SOFT_RST && q.mode_s[1] && !evt_any
      |=> q.status[8:2] == 7'h00 && q.srst ##1 !q.srst) else $error("Soft reset did not clear");
   a_srst_ignore: assert property ( // [R11]
      frame_done && cmd_w == CMD_SOFT_RST && !q.mode_s[1] && !evt_any
      |=> !q.srst && $stable(q.status[8:1])) else $error("Soft reset acted");
   a_sleep_wake: assert property ( // [R12]
      q.sleep && frame_done && cmd_w != CMD_SLEEP |=> !q.sleep)
      else $error("Command left front end asleep");
   a_perr_live: assert property (q.status[ST_PERR] == $past(perr)) // [R13]
      else $error("Parity flag not live");
endmodule
`default_nettype wire

// *** testbench/acs_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module acs_host (
   input  wire logic clk_sys,
   output logic      spi_cs_n,
   output logic      spi_sck,
   output logic      spi_sdi,
   input  wire logic spi_sdo
);
   initial begin
      spi_cs_n = 1'b1;
      spi_sck  = 1'b0;
      spi_sdi  = 1'b0;
   end
   task automatic hold();
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   task automatic frame(input logic [15:0] w, output logic [15:0] r);
      spi_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_sdi = w[i];
         hold();
         spi_sck = 1'b1;
         r = {r[14:0], spi_sdo};
         hold();
         spi_sck = 1'b0;
      end
      hold();
      spi_cs_n = 1'b1;
      // Released line must not keep a stale bit
      spi_sdi = ~spi_sdi;
      hold();
      hold();
   endtask
endmodule
`default_nettype wire

// *** testbench/afe_config_status_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module afe_config_status_regs_tb;
   import acs_pkg::*;
   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic        cs_n, sck, sdi, sdo, sl, cl, ap, srp, fea, gca, alm;
   logic [2:0]  cha, chw;
   logic [62:0] cfg;
   logic [8:0]  st;
   logic [15:0] r;
   logic [31:0] x = 32'h0000_244d;
   int          n_mismatch = 0, num_checks = 0, cyc = 0, npul = 0, est = 0;
   int          ecfg[7] = '{default: 0};
   acs_regs acs_regs_i (.clk_sys(clk_sys), .reset_n(reset_n), .spi_cs_n(cs_n),
      .spi_sck(sck), .spi_sdi(sdi), .spi_sdo(sdo), .chan_active(cha),
      .chan_woke(chw), .gain_ctrl_active(gca), .alarm_timeout(alm),
      .front_end_active(fea), .sleep_mode(sl), .clamp_on(cl),
      .agc_preserve(ap), .soft_reset_pulse(srp), .cfg_regs(cfg),
      .front_end_status(st));
   acs_host acs_host_i (.clk_sys(clk_sys), .spi_cs_n(cs_n), .spi_sck(sck),
      .spi_sdi(sdi), .spi_sdo(sdo));
   ////////////////////////////////////////////////////////////////
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (srp === 1'b1) npul++;
      // Whole run is near 2700 cycles
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   function automatic logic [31:0] rnd();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic int perr();
      int a = 0;
      int e = 0;
      for (int i = 0; i < 7; i++) begin
         a ^= ecfg[i];
         e |= int'(~^ecfg[i][8:0]);
      end
      return e | int'((a & 'h1fe) != 'h1fe);
   endfunction
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmp();
      chk("status", 16'(est | perr()), 16'(st));
      for (int i = 0; i < 7; i++) chk("cfg", 16'(ecfg[i]), 16'(cfg[9*i+:9]));
   endtask
   task automatic send(logic [2:0] c, logic [3:0] a, logic [7:0] d, logic bad);
      logic [8:0] v;
      v = {d, ~^d ^ bad};
      acs_host_i.frame({c, a, v}, r);
      if (c == CMD_WRITE && a < 7) ecfg[a] = int'(v);
      if (c == CMD_READ && a == STATUS_ADDR) est &= ~'h2;
      if (c == CMD_SOFT_RST && fea) est &= 'h3;
      cmp();
   endtask
   task automatic ev(logic [8:0] b);
      {cha, gca, chw, alm} = b[8:1];
      repeat (3) @(posedge clk_sys);
      #1 {cha, gca, chw, alm} = '0;
      repeat (6) @(posedge clk_sys);
      #1 est |= int'(b) & 'h1fe;
      cmp();
   endtask
   task automatic fin(string n);
      $display("test %s ended, %0d checks", n, num_checks);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      logic [8:0]  v;
      logic [15:0] es;
      {cha, chw, gca, alm, fea} = '0;
      repeat (2) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 cmp();
      for (int i = 0; i < 6; i++) send(CMD_WRITE, 4'(i), 8'(rnd()), 1'b0);
      v = '0;
      for (int i = 0; i < 6; i++) v ^= 9'(ecfg[i]);
      send(CMD_WRITE, COLPAR_ADDR, ~v[8:1], 1'b1);
      send(CMD_WRITE, COLPAR_ADDR, ~v[8:1], 1'b0);
      send(CMD_WRITE, STATUS_ADDR, 8'hff, 1'b0);
      fin("write");
      for (int i = 0; i < 4; i++) ev(9'(rnd()) | 9'h002);
      send(CMD_READ, 4'h3, 8'h00, 1'b0);
      send(CMD_READ, 4'h9, 8'h00, 1'b0);
      chk("rdata", 16'(ecfg[3]), r);
      // Status as read still carries the alarm; the clear follows the read
      es = 16'(est | perr());
      send(CMD_READ, STATUS_ADDR, 8'h00, 1'b0);
      chk("rdata", 16'h0000, r);
      fin("read");
      send(CMD_SLEEP, 4'h0, 8'h00, 1'b0);
      chk("rdata", es, r);
      chk("sleep", 16'h0001, 16'(sl));
      send(CMD_CLAMP_ON, 4'h0, 8'h00, 1'b0);
      chk("sleep", 16'h0000, 16'(sl));
      chk("clamp", 16'h0001, 16'(cl));
      send(CMD_PRES_ON, 4'h0, 8'h00, 1'b0);
      chk("preserve", 16'h0001, 16'(ap));
      ev(9'h1fe);
      send(CMD_SOFT_RST, 4'h0, 8'h00, 1'b0);
      chk("pulses", 16'h0000, 16'(npul));
      chk("preserve", 16'h0001, 16'(ap));
      fea = 1'b1;
      send(CMD_SOFT_RST, 4'h0, 8'h00, 1'b0);
      chk("pulses", 16'h0001, 16'(npul));
      chk("preserve", 16'h0000, 16'(ap));
      send(CMD_PRES_OFF, 4'h0, 8'h00, 1'b0);
      send(CMD_CLAMP_OFF, 4'h0, 8'h00, 1'b0);
      chk("clamp", 16'h0000, 16'(cl));
      fin("mode");
      wrap_up();
   end
endmodule
`default_nettype wire
